// *** include/mmmc_pkg.sv ***
// Package for the two-channel micro-step motor move control block
package mmmc_pkg;

  // ==========================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_MOTORS = 2;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ALPHA_MOVE_CTRL_OFS = 8'h24;
  localparam logic [7:0] BETA_MOVE_CTRL_OFS = 8'h29;
  localparam logic [7:0] MOVE_STATUS_OFS = 8'h2B;
  localparam logic [7:0] POSITION_OFS = 8'h2C;

  // ==========================================================
  // Field positions inside a motor move control register
  localparam int STEP_COUNT_LSB = 0;
  localparam int STEP_COUNT_W = 8;
  localparam int DIRECTION_BIT = 8;
  localparam int BRAKE_BIT = 9;
  localparam int OUTPUT_ENABLE_BIT = 10;
  localparam int DIVISION_LSB = 12;
  localparam int DIVISION_W = 2;

  // ==========================================================
  // Reset values
  localparam logic [15:0] MOVE_CTRL_RST = 16'h0000;
  localparam logic [7:0] POSITION_RST = 8'h00;

  // ==========================================================
  // Division select encodings
  localparam logic [1:0] DIV_256_A = 2'h0;
  localparam logic [1:0] DIV_256_B = 2'h1;
  localparam logic [1:0] DIV_128 = 2'h2;
  localparam logic [1:0] DIV_64 = 2'h3;

  // Microsteps per step-count unit at 256 divisions (8n)
  localparam int STEPS_PER_UNIT_SHIFT = 3;
  // Excitation position width: one electrical cycle in 256ths
  localparam int POS_W = 8;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] division_select;
    logic rsv_mid;
    logic output_enable;
    logic brake;
    logic direction;
    logic [7:0] step_count;
  } mmmc_move_ctrl_s;

  // One motor: two coil bridges, each with two half-bridge legs
  typedef struct packed {
    logic [1:0] high_a;
    logic [1:0] low_a;
    logic [1:0] high_b;
    logic [1:0] low_b;
    logic hiz;
  } mmmc_bridge_s;

endpackage

// *** logic/mmmc_top.sv ***
// Move control, excitation position counters and H-bridge gating for two motors
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Separate alpha and beta control registers
// - Count scaled 2n/4n/8n by division
// - Zero step count stops stepping
// - Zero count still energises current position
// - Direction 0 forward, 1 reverse
// - Brake bit 1 enters brake mode when output enable is 1
// - Brake turns on all high sides
// - Output enable 0 gives high impedance
// - Position keeps counting while outputs off
// - Division 00/01=256, 10=128, 11=64
module mmmc_top
  import mmmc_pkg::*;
#(
  parameter int STEP_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [mmmc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [mmmc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [mmmc_pkg::DATA_W-1:0] o_rdata,
  input wire logic [mmmc_pkg::NUM_MOTORS-1:0] i_step_tick,
  input wire logic [mmmc_pkg::NUM_MOTORS-1:0] i_pwm_on,
  input wire logic [mmmc_pkg::NUM_MOTORS-1:0] i_peak_nonzero,
  output mmmc_pkg::mmmc_bridge_s [mmmc_pkg::NUM_MOTORS-1:0] o_bridge,
  output logic [mmmc_pkg::NUM_MOTORS-1:0] o_busy
);
  import mmmc_pkg::*;

  // ==========================================================
  // Elaboration checks
  localparam int REM_W = STEP_W + STEPS_PER_UNIT_SHIFT;

  if (STEP_W != STEP_COUNT_W) begin : g_bad_step_w
    $error("STEP_W must match the step count field width");
  end

  // Offsets exist for the alpha and beta channels only
  if (NUM_MOTORS != 2) begin : g_bad_motors
    $error("NUM_MOTORS must be 2");
  end

  if ($bits(mmmc_move_ctrl_s) != DATA_W) begin : g_bad_ctrl_w
    $error("Motor register carrier must fill the data width");
  end

  // The carrier fixes the layout; the named positions must agree with it
  if (DIRECTION_BIT != STEP_COUNT_LSB + STEP_COUNT_W) begin : g_bad_dir_bit
    $error("Direction must sit just above the step count");
  end

  if (BRAKE_BIT != DIRECTION_BIT + 1) begin : g_bad_brake_bit
    $error("Brake must sit just above direction");
  end

  if (OUTPUT_ENABLE_BIT != BRAKE_BIT + 1) begin : g_bad_oe_bit
    $error("Output enable must sit just above brake");
  end

  if (DIVISION_LSB != OUTPUT_ENABLE_BIT + 2) begin : g_bad_div_lsb
    $error("Division select must leave one reserved bit below it");
  end

  if (DIVISION_LSB + DIVISION_W > DATA_W) begin : g_bad_div_w
    $error("Division select must fit the data width");
  end

  // Both positions are returned in one read word
  if (2 * POS_W > DATA_W) begin : g_bad_pos_w
    $error("Both positions must fit one read word");
  end

  // ==========================================================
  // Decode helpers

  // Shift of the position advance per microstep, in 256ths
  function automatic logic [1:0] div_shift(input logic [1:0] sel);
    logic [1:0] s;
    s = 2'h0;
    case (sel)
      DIV_256_A: s = 2'h0;
      DIV_256_B: s = 2'h0;
      DIV_128: s = 2'h1;
      DIV_64: s = 2'h2;
      default: s = 2'h0;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] motor_offset(input int m);
    logic [7:0] ofs;
    ofs = (m == 0) ? ALPHA_MOVE_CTRL_OFS : BETA_MOVE_CTRL_OFS;
    return ofs;
  endfunction

  // Microsteps loaded for a step count: 8n, 4n or 2n
  function automatic logic [REM_W-1:0] load_count(
    input logic [STEP_W-1:0] n,
    input logic [1:0] sel
  );
    logic [REM_W-1:0] c;
    c = REM_W'(n) << (STEPS_PER_UNIT_SHIFT - int'(div_shift(sel)));
    return c;
  endfunction

  // High and low legs of one coil, diagonal pairs only
  function automatic logic [3:0] coil_legs(input logic positive);
    logic [3:0] legs;
    legs = positive ? 4'h6 : 4'h9;
    return legs;
  endfunction

  // ==========================================================
  // Per-motor state
  mmmc_move_ctrl_s ctrl_ff [NUM_MOTORS];
  mmmc_move_ctrl_s nxt_ctrl [NUM_MOTORS];
  logic [REM_W-1:0] remain_ff [NUM_MOTORS];
  logic [REM_W-1:0] nxt_remain [NUM_MOTORS];
  logic [POS_W-1:0] pos_ff [NUM_MOTORS];
  logic [POS_W-1:0] nxt_pos [NUM_MOTORS];
  mmmc_bridge_s bridge_ff [NUM_MOTORS];
  mmmc_bridge_s nxt_bridge [NUM_MOTORS];
  logic [NUM_MOTORS-1:0] busy_ff;
  logic [NUM_MOTORS-1:0] nxt_busy;
  wire logic [NUM_MOTORS-1:0] wr_hit;
  wire logic [NUM_MOTORS-1:0] step_en;
  wire logic [POS_W-1:0] delta [NUM_MOTORS];
  mmmc_move_ctrl_s wr_val;

  // ==========================================================
  // Write word with reserved bits cleared
  always_comb begin
    wr_val = mmmc_move_ctrl_s'(i_wdata);
    // reserved bits always read back as zero
    wr_val.rsv_hi = 2'h0;
    wr_val.rsv_mid = 1'b0;
  end

  for (genvar m = 0; m < NUM_MOTORS; m++) begin : g_motor

    // ========================================================
    // Request decode
    // independent register per motor
    assign wr_hit[m] = i_wr && (i_addr == motor_offset(m));
    // advance regardless of output enable or brake
    assign step_en[m] = i_step_tick[m] && (remain_ff[m] != REM_W'(0));
    assign delta[m] = POS_W'(1) << div_shift(ctrl_ff[m].division_select);

    // ========================================================
    // Control register
    always_comb begin
      nxt_ctrl[m] = ctrl_ff[m];
      if (wr_hit[m]) begin
        nxt_ctrl[m] = wr_val;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        ctrl_ff[m] <= mmmc_move_ctrl_s'(MOVE_CTRL_RST);
      end else if (i_ce) begin
        ctrl_ff[m] <= nxt_ctrl[m];
      end
    end

    // ========================================================
    // Remaining microsteps
    always_comb begin
      nxt_remain[m] = remain_ff[m];
      if (wr_hit[m]) begin
        // count scaled so rotation is division independent
        // a zero count loads nothing to move
        nxt_remain[m] = load_count(wr_val.step_count, wr_val.division_select);
      end else if (step_en[m]) begin
        nxt_remain[m] = remain_ff[m] - REM_W'(1);
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        remain_ff[m] <= REM_W'(0);
      end else if (i_ce) begin
        remain_ff[m] <= nxt_remain[m];
      end
    end

    // ========================================================
    // Excitation position
    // A write beats a tick in the same cycle; that tick is lost
    always_comb begin
      nxt_pos[m] = pos_ff[m];
      if (!wr_hit[m] && step_en[m]) begin
        if (ctrl_ff[m].direction) begin
          nxt_pos[m] = pos_ff[m] - delta[m];
        end else begin
          nxt_pos[m] = pos_ff[m] + delta[m];
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        pos_ff[m] <= POSITION_RST;
      end else if (i_ce) begin
        pos_ff[m] <= nxt_pos[m];
      end
    end

    // ========================================================
    // Bridge gating follows the position already committed
    always_comb begin
      logic [1:0] quad;
      logic [3:0] legs_a;
      logic [3:0] legs_b;
      logic drive;
      quad = pos_ff[m][POS_W-1:POS_W-2];
      // Coil A carries the cosine, coil B the sine
      legs_a = coil_legs((quad == 2'h0) || (quad == 2'h3));
      legs_b = coil_legs((quad == 2'h0) || (quad == 2'h1));
      // hold excitation while the count is spent
      drive = i_pwm_on[m] && i_peak_nonzero[m];
      nxt_bridge[m] = '0;
      if (!ctrl_ff[m].output_enable) begin
        nxt_bridge[m].hiz = 1'b1;
      end else if (ctrl_ff[m].brake) begin
        // both high sides on, lows off
        nxt_bridge[m].high_a = 2'h3;
        nxt_bridge[m].high_b = 2'h3;
      end else if (drive) begin
        // Diagonal pairs only, so no leg ever shoots through
        nxt_bridge[m].high_a = legs_a[3:2];
        nxt_bridge[m].low_a = legs_a[1:0];
        nxt_bridge[m].high_b = legs_b[3:2];
        nxt_bridge[m].low_b = legs_b[1:0];
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        bridge_ff[m] <= '{hiz: 1'b1, default: '0};
      end else if (i_ce) begin
        bridge_ff[m] <= nxt_bridge[m];
      end
    end

    // ========================================================
    // Busy flag tracks the remaining count it will commit
    always_comb begin
      nxt_busy[m] = (nxt_remain[m] != REM_W'(0));
    end

    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        busy_ff[m] <= 1'b0;
      end else if (i_ce) begin
        busy_ff[m] <= nxt_busy[m];
      end
    end

    assign o_bridge[m] = bridge_ff[m];
  end

  assign o_busy = busy_ff;

  // ==========================================================
  // Read port: data stand in the cycle after the strobe only
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        ALPHA_MOVE_CTRL_OFS: nxt_rdata = DATA_W'(ctrl_ff[0]);
        BETA_MOVE_CTRL_OFS: nxt_rdata = DATA_W'(ctrl_ff[1]);
        MOVE_STATUS_OFS: nxt_rdata = DATA_W'(busy_ff);
        POSITION_OFS: nxt_rdata = {pos_ff[1], pos_ff[0]};
        // Unmapped offsets read as zero
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_ff <= '0;
    end else if (i_ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

endmodule

`default_nettype wire

// *** tb/mmmc_top_asserts.sv ***
// Concurrent checks on the motor move control ports
`timescale 1ns/1ps
`default_nettype none
module mmmc_top_asserts
  import mmmc_pkg::*;
#(
  parameter int STEP_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [mmmc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [mmmc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [mmmc_pkg::DATA_W-1:0] o_rdata,
  input wire logic [mmmc_pkg::NUM_MOTORS-1:0] i_step_tick,
  input wire mmmc_pkg::mmmc_bridge_s [mmmc_pkg::NUM_MOTORS-1:0] o_bridge,
  input wire logic [mmmc_pkg::NUM_MOTORS-1:0] o_busy
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire logic wa = i_ce && i_wr && i_addr == 8'h24;
  wire logic wb = i_ce && i_wr && i_addr == 8'h29;
  sequence s_brake_wr;
    wa && i_wdata[10:9] == 2'h3;
  endsequence
  sequence s_off_wr;
    wa && !i_wdata[10];
  endsequence
  a_read_idle_zero: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data not zero when idle");
  a_busy_on_load: assert property (wa && i_wdata[7:0] != 8'h0 |=> o_busy[0])
    else $error("alpha not busy after load");
  a_zero_stops: assert property (wa && i_wdata[7:0] == 8'h0 |=> !o_busy[0])
    else $error("alpha busy after zero count");
  a_busy_holds: assert property (o_busy[0] && !i_step_tick[0] && !wa |=> o_busy[0])
    else $error("alpha stopped without tick");
  a_idle_stays: assert property (!o_busy[0] && !wa |=> !o_busy[0])
    else $error("alpha moved without load");
  a_beta_busy: assert property (wb && i_wdata[7:0] != 8'h0 |=> o_busy[1])
    else $error("beta not busy after load");
  a_brake_high: assert property (s_brake_wr |-> ##2 o_bridge[0].high_a == 2'h3
    && o_bridge[0].high_b == 2'h3 && o_bridge[0].low_a == 2'h0)
    else $error("brake bridge pattern wrong");
  a_off_hiz: assert property (s_off_wr |-> ##2 o_bridge[0].hiz && o_bridge[0].high_a == 2'h0)
    else $error("disabled bridge not floating");
endmodule
bind mmmc_top mmmc_top_asserts #(.STEP_W(STEP_W)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_step_tick(i_step_tick), .o_bridge(o_bridge), .o_busy(o_busy));
`default_nettype wire

// *** tb/mmmc_motor_model.sv ***
// Two motors seen through their bridges: floating, braked or driven
`timescale 1ns/1ps
`default_nettype none
module mmmc_motor_model
  import mmmc_pkg::*;
(
  input wire mmmc_pkg::mmmc_bridge_s [1:0] i_bridge,
  output logic [1:0] o_float,
  output logic [1:0] o_brake,
  output logic [1:0] o_drive
);
  // ==========================================================
  // Coil state
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      o_float[m] = i_bridge[m].hiz;
      o_brake[m] = &{i_bridge[m].high_a, i_bridge[m].high_b};
      // Driven when any coil A high leg and any coil A low leg are on and not floating
      o_drive[m] = (|i_bridge[m].high_a) && (|i_bridge[m].low_a) && !i_bridge[m].hiz;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_mmmc_top.sv ***
// Self-checking bench for the motor move control block
`timescale 1ns/1ps
`default_nettype none
module tb_mmmc_top;
  import mmmc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic [1:0] i_step_tick = 2'h0;
  logic i_ce = 1'b1;
  logic [1:0] i_peak_nonzero = 2'h3;
  logic [15:0] o_rdata, rv, ctl;
  logic [1:0] o_busy, m_float, m_brake, m_drive;
  mmmc_bridge_s [1:0] o_bridge;
  int n_fail = 0;
  int total_checks = 0;
  integer seed = 32'hFC656D4A;
  mmmc_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_step_tick(i_step_tick), .i_pwm_on(2'h3), .i_peak_nonzero(i_peak_nonzero),
    .o_bridge(o_bridge), .o_busy(o_busy));
  mmmc_motor_model u_motor (.i_bridge(o_bridge), .o_float(m_float), .o_brake(m_brake),
    .o_drive(m_drive));
  initial forever #2 i_clk = ~i_clk;
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  function automatic logic [15:0] steps(input logic [7:0] n, input logic [1:0] dv);
    return (dv == 2'h3) ? 16'(n * 2) : (dv == 2'h2) ? 16'(n * 4) : 16'(n * 8);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_fail++;
    end_of_test();
  end
  // ==========================================================
  // Tests
  initial begin
    int m, k, t, cnt;
    logic [7:0] n, p0, pe;
    logic [1:0] dv;
    logic dir, en;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h24);
    chk(rv, 16'h0000);
    rd(8'h29);
    chk(rv, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      m = i % 2;
      dv = (i == 4) ? 2'h3 : 2'(i);
      n = (i == 4) ? 8'hFF : 8'({$random(seed)} % 5 + 1);
      dir = $random(seed);
      en = i > 1;
      ctl = {2'h0, dv, 1'b0, en, 1'b0, dir, n};
      rd(8'h2C);
      p0 = m ? rv[15:8] : rv[7:0];
      wr(m ? 8'h29 : 8'h24, ctl | 16'hC800);
      cnt = 0;
      k = 0;
      while (o_busy[m] === 1'b1 && k < 3000) begin
        @(posedge i_clk);
        t = $random(seed) & 1;
        i_step_tick[m] <= t[0];
        @(posedge i_clk);
        i_step_tick[m] <= 1'b0;
        cnt += t;
        k++;
        #1;
      end
      chk(16'(cnt), steps(n, dv));
      rd(m ? 8'h29 : 8'h24);
      chk(rv, ctl);
      rd(8'h2C);
      pe = dir ? p0 - 8'(n * 8) : p0 + 8'(n * 8);
      chk({8'h0, m ? rv[15:8] : rv[7:0]}, {8'h0, pe});
      $display("move test %0d done", i);
    end
    wr(8'h24, 16'h0528);
    wr(8'h24, 16'h0400);
    chk(o_busy, 2'h0);
    rd(8'h2B);
    chk(rv, 16'h0000);
    settle();
    chk(m_drive[0], 1'b1);
    @(posedge i_clk);
    i_peak_nonzero <= 2'h2;
    settle();
    chk({m_drive[0], m_float[0]}, 2'h0);
    i_peak_nonzero <= 2'h3;
    i_ce <= 1'b0;
    wr(8'h24, 16'h0000);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rd(8'h24);
    chk(rv, 16'h0400);
    wr(8'h24, 16'h0600);
    settle();
    chk(m_brake[0], 1'b1);
    wr(8'h24, 16'h0000);
    settle();
    chk(m_float[0], 1'b1);
    rd(8'h31);
    chk(rv, 16'h0000);
    $display("stop test done");
    end_of_test();
  end
endmodule
`default_nettype wire
